// *** rtl/spp_parser.sv ***
// program message parser: terminators, units, headers, separators, whitespace
// Contract
// - a line feed byte ends the program message.
// - carriage return followed by line feed ends the message like a lone line feed.
// - end-or-identify line low with a byte closes the current message.
// - bytes 00..09 and 0b..20 are whitespace; line feed is not.
// - whitespace never triggers a control action; treated as space or dropped.
// - a message is released for execution only after its terminator.
// - zero, one or more units per message; bare terminator is an empty message.
// - semicolon splits units; whitespace around it is ignored.
// - a header without parameters is a complete unit.
// - header ending in question mark is a query, otherwise a command.
// - whitespace in front of each header is skipped.
// - numeric suffix bytes are digits 30..39.
// - leading asterisk marks a common-command header.
// - mnemonic starts with a letter, then letters, digits or underscore.
// - mnemonics longer than twelve characters are rejected.
// - letters are 41..5a and 61..7a.
// - byte 5f is the underscore allowed inside mnemonics.
// - only the first whitespace after a header separates; the rest is dropped.
// - commas split parameters; whitespace around them is ignored.
// - short and long mnemonic spellings obey the same character checks.
`timescale 1ns/10ps
module spp_parser
    import spp_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // incoming bytes from the input buffer
    input  wire logic       rx_valid,
    output logic            rx_ready,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_eoi_n,
    // parsed token stream
    output logic            tok_valid,
    input  wire logic       tok_ready,
    output logic [7:0]      tok_byte,
    output spp_pkg::spp_tok_t tok_kind,
    output logic            tok_query,
    output logic            tok_common,
    // status
    output logic            syntax_err_q
);
    import spp_pkg::*;

    // ******************************************************************
    // state and storage
    // ******************************************************************
    typedef enum {
        SPP_ST_PRE,      // before a header, skipping whitespace
        SPP_ST_STAR,     // asterisk seen, mnemonic must follow
        SPP_ST_MNEM,     // inside a mnemonic
        SPP_ST_COLON,    // colon seen, mnemonic must follow
        SPP_ST_HDR_END,  // header closed by whitespace
        SPP_ST_QRY,      // query mark seen
        SPP_ST_DATA,     // inside a parameter
        SPP_ST_DWS,      // whitespace after a parameter
        SPP_ST_PSEP,     // comma seen, next parameter due
        SPP_ST_DISCARD   // error: drop bytes up to the terminator
    } spp_state_t;

    spp_state_t state_q, state_d;
    logic [3:0] mlen_q, mlen_d;
    logic       cr_q, cr_d;
    logic       query_q, query_d;
    logic       common_q, common_d;
    logic       err_d;
    logic       eoi_s1_q, eoi_s2_q;
    logic       pend_q, pend_d;
    logic [7:0] pend_byte_q;

    // ******************************************************************
    // byte classes
    // ******************************************************************
    wire is_lf    = (rx_byte == SPP_LF);
    wire is_ws    = (rx_byte <= SPP_WS_LO_END) ||
                    ((rx_byte >= SPP_WS_HI_BEG) && (rx_byte <= SPP_WS_HI_END));
    wire is_cr    = (rx_byte == SPP_CR);
    wire is_upper = (rx_byte >= SPP_UC_LO) && (rx_byte <= SPP_UC_HI);
    wire is_lower = (rx_byte >= SPP_LC_LO) && (rx_byte <= SPP_LC_HI);
    wire is_alpha = is_upper || is_lower;
    wire is_digit = (rx_byte >= SPP_DIG_LO) && (rx_byte <= SPP_DIG_HI);
    wire is_under = (rx_byte == SPP_UNDER);
    wire is_mchar = is_alpha || is_digit || is_under;
    wire is_semi  = (rx_byte == SPP_SEMI);
    wire is_comma = (rx_byte == SPP_COMMA);
    wire is_qry   = (rx_byte == SPP_QUERY);
    wire is_star  = (rx_byte == SPP_STAR);
    wire is_colon = (rx_byte == SPP_COLON);
    // eoi is a pin, so it is synchronised; bytes and eoi come from the same
    // transport, so the caller must hold eoi low until the last byte is taken
    wire eoi      = !eoi_s2_q;
    wire take     = clk_en && rx_valid && rx_ready;

    // ******************************************************************
    // next state
    // ******************************************************************
    logic       emit;
    spp_tok_t   emit_kind;
    logic [7:0] emit_byte;
    logic       buf_ready;
    wire        pend_drain = clk_en && pend_q && buf_ready;
    logic       msg_end;

    // a cr is dropped: cr+lf is one terminator, a lone cr is skipped without effect
    assign msg_end = is_lf || eoi;

    always_comb begin
        state_d   = state_q;
        mlen_d    = mlen_q;
        cr_d      = 1'b0;
        query_d   = query_q;
        common_d  = common_q;
        err_d     = 1'b0;
        pend_d    = 1'b0;
        emit      = 1'b0;
        emit_kind = SPP_TK_HDR;
        emit_byte = rx_byte;
        if (msg_end && state_q != SPP_ST_STAR && state_q != SPP_ST_COLON
            && state_q != SPP_ST_PSEP) begin
            // every open unit closes; the message is released, or dropped as an error if in discard
            emit      = 1'b1;
            emit_kind = (state_q == SPP_ST_DISCARD) ? SPP_TK_ERR : SPP_TK_MSG;
            emit_byte = SPP_LF;
            state_d   = SPP_ST_PRE;
            query_d   = 1'b0;
            common_d  = 1'b0;
            mlen_d    = 4'h0;
        end else if (msg_end) begin
            // a dangling star, colon or comma is a syntax break
            emit      = 1'b1;
            emit_kind = SPP_TK_ERR;
            emit_byte = SPP_LF;
            err_d     = 1'b1;
            state_d   = SPP_ST_PRE;
            query_d   = 1'b0;
            common_d  = 1'b0;
            mlen_d    = 4'h0;
        end else if (is_cr && !cr_q && state_q != SPP_ST_DISCARD) begin
            cr_d = 1'b1;
        end else begin
            case (state_q)
                SPP_ST_PRE: begin
                    if (is_ws || is_semi) begin
                        state_d = SPP_ST_PRE;
                    end else if (is_star) begin
                        common_d = 1'b1;
                        query_d  = 1'b0;
                        emit     = 1'b1;
                        state_d  = SPP_ST_STAR;
                    end else if (is_colon) begin
                        // flags belong to one unit, so a new header starts clean
                        common_d = 1'b0;
                        query_d  = 1'b0;
                        emit    = 1'b1;
                        state_d = SPP_ST_COLON;
                    end else if (is_alpha) begin
                        common_d = 1'b0;
                        query_d  = 1'b0;
                        emit    = 1'b1;
                        mlen_d  = 4'h1;
                        state_d = SPP_ST_MNEM;
                    end else begin
                        state_d = SPP_ST_DISCARD;
                        err_d   = 1'b1;
                    end
                end
                SPP_ST_STAR, SPP_ST_COLON: begin
                    if (is_alpha) begin
                        emit    = 1'b1;
                        mlen_d  = 4'h1;
                        state_d = SPP_ST_MNEM;
                    end else begin
                        state_d = SPP_ST_DISCARD;
                        err_d   = 1'b1;
                    end
                end
                SPP_ST_MNEM: begin
                    if (is_mchar) begin
                        if (mlen_q == SPP_MNEM_MAX) begin
                            state_d = SPP_ST_DISCARD;
                            err_d   = 1'b1;
                        end else begin
                            emit   = 1'b1;
                            mlen_d = mlen_q + 4'h1;
                        end
                    end else if (is_colon && !common_q) begin
                        emit    = 1'b1;
                        state_d = SPP_ST_COLON;
                    end else if (is_qry) begin
                        emit    = 1'b1;
                        query_d = 1'b1;
                        state_d = SPP_ST_QRY;
                    end else if (is_ws) begin
                        state_d = SPP_ST_HDR_END;
                    end else if (is_semi) begin
                        emit      = 1'b1;
                        emit_kind = SPP_TK_UNIT;
                        state_d   = SPP_ST_PRE;
                    end else begin
                        state_d = SPP_ST_DISCARD;
                        err_d   = 1'b1;
                    end
                end
                SPP_ST_QRY, SPP_ST_HDR_END: begin
                    if (is_ws && state_q == SPP_ST_QRY) begin
                        state_d = SPP_ST_HDR_END;
                    end else if (is_ws) begin
                        state_d = SPP_ST_HDR_END;
                    end else if (is_semi) begin
                        emit      = 1'b1;
                        emit_kind = SPP_TK_UNIT;
                        state_d   = SPP_ST_PRE;
                    end else if (state_q == SPP_ST_HDR_END && !is_comma) begin
                        // header separator was seen, so parameters may start
                        emit      = 1'b1;
                        emit_kind = SPP_TK_DATA;
                        state_d   = SPP_ST_DATA;
                    end else begin
                        state_d = SPP_ST_DISCARD;
                        err_d   = 1'b1;
                    end
                end
                SPP_ST_DATA, SPP_ST_DWS: begin
                    if (is_ws) begin
                        state_d = SPP_ST_DWS;
                    end else if (is_comma) begin
                        emit      = 1'b1;
                        emit_kind = SPP_TK_PSEP;
                        state_d   = SPP_ST_PSEP;
                    end else if (is_semi) begin
                        emit      = 1'b1;
                        emit_kind = SPP_TK_UNIT;
                        state_d   = SPP_ST_PRE;
                    end else if (state_q == SPP_ST_DWS) begin
                        // inner blank goes out as one space; the byte that ends it
                        // is parked and follows in a later cycle, once the buffer has room
                        emit      = 1'b1;
                        emit_kind = SPP_TK_DATA;
                        emit_byte = SPP_SPACE;
                        state_d   = SPP_ST_DATA;
                        pend_d    = 1'b1;
                    end else begin
                        emit      = 1'b1;
                        emit_kind = SPP_TK_DATA;
                    end
                end
                SPP_ST_PSEP: begin
                    if (is_ws) begin
                        state_d = SPP_ST_PSEP;
                    end else if (is_comma || is_semi) begin
                        state_d = SPP_ST_DISCARD;
                        err_d   = 1'b1;
                    end else begin
                        emit      = 1'b1;
                        emit_kind = SPP_TK_DATA;
                        state_d   = SPP_ST_DATA;
                    end
                end
                SPP_ST_DISCARD: begin
                    state_d = SPP_ST_DISCARD;
                end
                default: begin
                    state_d = SPP_ST_DISCARD;
                end
            endcase
        end
    end

    // ******************************************************************
    // registers
    // ******************************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            eoi_s1_q <= 1'b1;
            eoi_s2_q <= 1'b1;
        end else if (clk_en) begin
            eoi_s1_q <= rx_eoi_n;
            eoi_s2_q <= eoi_s1_q;
        end
    end

    // intake stops while a parked byte waits, so no byte is ever lost
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= 1'b0;
        end else if (take && pend_d) begin
            pend_q <= 1'b1;
        end else if (pend_drain) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (take && pend_d) pend_byte_q <= rx_byte;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q      <= SPP_ST_PRE;
            mlen_q       <= 4'h0;
            cr_q         <= 1'b0;
            query_q      <= 1'b0;
            common_q     <= 1'b0;
            syntax_err_q <= 1'b0;
        end else if (take) begin
            state_q      <= state_d;
            mlen_q       <= mlen_d;
            cr_q         <= cr_d;
            query_q      <= query_d;
            common_q     <= common_d;
            syntax_err_q <= err_d;
        end else if (clk_en) begin
            syntax_err_q <= 1'b0;
        end
    end

    // ******************************************************************
    // output buffer: a stalled consumer stalls byte intake
    // ******************************************************************
    localparam int TOK_W = 13;
    wire [TOK_W-1:0] tok_in = pend_q ? {SPP_TK_DATA, query_q, common_q, pend_byte_q}
                                     : {emit_kind, query_d, common_d, emit_byte};
    wire [TOK_W-1:0] tok_out;

    assign rx_ready = buf_ready && !pend_q;

    spp_skid_buf #(
        .WIDTH (TOK_W)
    ) u_buf (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .in_valid  ((take && emit) || pend_drain),
        .in_ready  (buf_ready),
        .in_data   (tok_in),
        .out_valid (tok_valid),
        .out_ready (tok_ready),
        .out_data  (tok_out)
    );

    assign tok_kind   = spp_tok_t'(tok_out[12:10]);
    assign tok_query  = tok_out[9];
    assign tok_common = tok_out[8];
    assign tok_byte   = tok_out[7:0];

    // ******************************************************************
    // checks
    // ******************************************************************
    chk_lf_ends_msg: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take && is_lf) |=> (state_q == SPP_ST_PRE))
        else $error("line feed did not close the message");
    chk_ws_no_emit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take && is_ws && !eoi && state_q == SPP_ST_PRE) |-> !emit)
        else $error("leading whitespace produced a token");
    chk_long_mnem: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take && !eoi && state_q == SPP_ST_MNEM && mlen_q == SPP_MNEM_MAX && is_mchar)
        |=> syntax_err_q)
        else $error("thirteenth mnemonic character accepted");
    chk_query_mark: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take && !eoi && state_q == SPP_ST_MNEM && is_qry) |=> query_q)
        else $error("query mark did not mark a query");
    chk_discard_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take && state_q == SPP_ST_DISCARD && !msg_end) |=> state_q == SPP_ST_DISCARD)
        else $error("discard left before terminator");
    chk_comma_token: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take && !eoi && state_q == SPP_ST_DATA && is_comma) |-> emit_kind == SPP_TK_PSEP)
        else $error("comma not split into parameter boundary");
    chk_star_common: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take && !eoi && state_q == SPP_ST_PRE && is_star) |=> common_q)
        else $error("asterisk did not mark common header");
    chk_msg_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take && emit && emit_kind == SPP_TK_MSG) |-> msg_end)
        else $error("message released without terminator");
endmodule // spp_parser

// *** rtl/spp_pkg.sv ***
// package: byte codes, token kinds and limits of the program message parser
package spp_pkg;
    // byte codes
    localparam logic [7:0] SPP_LF        = 8'h0a;
    localparam logic [7:0] SPP_CR        = 8'h0d;
    localparam logic [7:0] SPP_WS_LO_END = 8'h09;
    localparam logic [7:0] SPP_WS_HI_BEG = 8'h0b;
    localparam logic [7:0] SPP_WS_HI_END = 8'h20;
    localparam logic [7:0] SPP_SPACE     = 8'h20;
    localparam logic [7:0] SPP_SEMI      = 8'h3b;
    localparam logic [7:0] SPP_COMMA     = 8'h2c;
    localparam logic [7:0] SPP_QUERY     = 8'h3f;
    localparam logic [7:0] SPP_STAR      = 8'h2a;
    localparam logic [7:0] SPP_COLON     = 8'h3a;
    localparam logic [7:0] SPP_DIG_LO    = 8'h30;
    localparam logic [7:0] SPP_DIG_HI    = 8'h39;
    localparam logic [7:0] SPP_UC_LO     = 8'h41;
    localparam logic [7:0] SPP_UC_HI     = 8'h5a;
    localparam logic [7:0] SPP_LC_LO     = 8'h61;
    localparam logic [7:0] SPP_LC_HI     = 8'h7a;
    localparam logic [7:0] SPP_UNDER     = 8'h5f;
    // longest mnemonic in characters
    localparam logic [3:0] SPP_MNEM_MAX  = 4'hc;
    // buffer depth (entries)
    localparam int         SPP_BUF_DEPTH = 2;

    // token kind written with each output byte
    typedef enum logic [2:0] {
        SPP_TK_HDR   = 3'h0,  // header byte (mnemonic, colon, star, query mark)
        SPP_TK_DATA  = 3'h1,  // parameter byte
        SPP_TK_PSEP  = 3'h2,  // parameter boundary (comma)
        SPP_TK_UNIT  = 3'h3,  // end of message unit
        SPP_TK_MSG   = 3'h4,  // end of program message, release for execution
        SPP_TK_ERR   = 3'h5   // message discarded on syntax error
    } spp_tok_t;
endpackage : spp_pkg

// *** rtl/spp_skid_buf.sv ***
// two-entry valid/ready buffer between parser and consumer
`timescale 1ns/10ps
module spp_skid_buf #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wr_ptr_q;
    logic             rd_ptr_q;
    logic [1:0]       cnt_q;
    wire              push = clk_en && in_valid && (cnt_q != 2'h2);
    wire              pop  = clk_en && out_ready && (cnt_q != 2'h0);

    // ready and valid are decoded from the registered count only, not from either side's inputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            if (push) wr_ptr_q <= ~wr_ptr_q;
            if (pop)  rd_ptr_q <= ~rd_ptr_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) mem_q[wr_ptr_q] <= in_data;
    end

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_ptr_q];

    chk_buf_no_overflow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cnt_q <= 2'h2) else $error("buffer count exceeds depth");
    chk_buf_hold_word: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (out_valid && !pop) |=> (out_valid && $stable(out_data)))
        else $error("held word changed before it was taken");
endmodule // spp_skid_buf

// *** test/spp_talker.sv ***
// talker model: offers program message bytes to the parser
`timescale 1ns/10ps
module spp_talker (
    // clock and enable
    input  wire logic  clk_sys,
    input  wire logic  clk_en,
    // byte handshake
    output logic       rx_valid,
    input  wire logic  rx_ready,
    output logic [7:0] rx_byte,
    output logic       rx_eoi_n
);
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
        rx_eoi_n = 1'b1;
    end
    // entered just after a rising edge; eoi turns the last byte into the end mark
    task automatic send(input string s, input bit eoi);
        for (int i = 0; i < s.len(); i++) begin
            if (eoi && i == s.len() - 1) begin
                // end line drops two edges early so the synchroniser has seen it
                rx_valid = 1'b0;
                rx_eoi_n = 1'b0;
                repeat (2) @(posedge clk_sys);
                #2;
            end
            rx_byte  = s[i];
            rx_valid = 1'b1;
            do @(posedge clk_sys); while (rx_ready !== 1'b1 || clk_en !== 1'b1);
            #2;
        end
        rx_valid = 1'b0;
        rx_eoi_n = 1'b1;
        // released byte lines must not look like the last byte
        rx_byte  = ~rx_byte;
    endtask
endmodule // spp_talker

// *** test/test_spp_parser.sv ***
// testbench of the program message parser
`timescale 1ns/10ps
module test_spp_parser;
    import spp_pkg::*;
    logic       clk_sys, reset_n, clk_en, hold, tok_ready, tok_valid, tok_query, tok_common;
    logic       rx_valid, rx_ready, rx_eoi_n, syntax_err_q;
    logic [7:0] rx_byte, tok_byte;
    logic [1:0] cyc;
    spp_tok_t   tok_kind;
    string      sig;
    int         fail_count, num_checks, qcnt, ccnt, ecnt, full_seen;

    spp_talker u_spp_talker (.clk_sys(clk_sys), .clk_en(clk_en), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_eoi_n(rx_eoi_n));
    spp_parser u_spp_parser (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_eoi_n(rx_eoi_n),
        .tok_valid(tok_valid), .tok_ready(tok_ready), .tok_byte(tok_byte),
        .tok_kind(tok_kind), .tok_query(tok_query), .tok_common(tok_common),
        .syntax_err_q(syntax_err_q));

    // ****************************
    // consumer: stalls one cycle in four, or fully while hold is up
    // ****************************
    assign tok_ready = !hold && cyc != 2'h0;
    function automatic string ch(input logic [7:0] b);
        string c;
        c = " ";
        c[0] = b;
        return c;
    endfunction
    always @(posedge clk_sys) begin
        cyc <= cyc + 2'h1;
        if (rx_ready === 1'b0) full_seen++;
        if (syntax_err_q === 1'b1) ecnt++;
        if (tok_valid === 1'b1 && tok_ready) begin
            if (tok_kind === SPP_TK_HDR && tok_query === 1'b1) qcnt++;
            if (tok_kind === SPP_TK_HDR && tok_common === 1'b1) ccnt++;
            case (tok_kind)
                SPP_TK_HDR:  sig = {sig, ch(tok_byte)};
                SPP_TK_DATA: sig = {sig, "=", ch(tok_byte)};
                SPP_TK_PSEP: sig = {sig, ","};
                SPP_TK_UNIT: sig = {sig, ";"};
                SPP_TK_MSG:  sig = {sig, "$"};
                default:     sig = {sig, "!"};
            endcase
        end
    end

    task automatic check(input string nm, input string seen, input string exp);
        num_checks++;
        if (seen != exp) begin
            fail_count++;
            $display("ERROR %s expected %s seen %s", nm, exp, seen);
        end
    endtask
    task automatic run(input string s, input bit eoi, input string exp, input string nm);
        int n;
        sig = "";
        u_spp_talker.send(s, eoi);
        n = 0;
        while (sig.len() < exp.len() && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (4) @(posedge clk_sys);
        #2;
        check(nm, sig, exp);
    endtask
    task automatic t_term();
        qcnt = 0;
        run("A?\n", 1'b0, "A?$", "query");
        check("query flag", $sformatf("%0d", qcnt), "1");
        run("B\r\n", 1'b0, "B$", "crlf");
        run("\n", 1'b0, "$", "empty");
        run("CDx", 1'b1, "CD$", "eoi");
        run("EF", 1'b0, "EF", "open");
        run("\n", 1'b0, "$", "close");
        $display("test terminators done");
    endtask
    task automatic t_units();
        ccnt = 0;
        qcnt = 0;
        run(" *RST ; :sOURce1? \t;X_9\n", 1'b0, "*RST;:sOURce1?;X_9$", "units");
        check("common", $sformatf("%0d", ccnt), "4");
        check("query per unit", $sformatf("%0d", qcnt), "1");
        run("\001\t\013 K\n", 1'b0, "K$", "ws edges");
        run("!K\n", 1'b0, "!", "not ws");
        $display("test units done");
    endtask
    task automatic t_data();
        full_seen = 0;
        hold = 1'b1;
        fork
            begin
                repeat (30) @(posedge clk_sys);
                #2;
                hold = 1'b0;
            end
        join_none
        run("SRC  1 , 2,a\tb\n", 1'b0, "SRC=1,=2,=a= =b$", "data");
        check("stall", $sformatf("%0d", full_seen > 0), "1");
        clk_en = 1'b0;
        fork
            begin
                repeat (10) @(posedge clk_sys);
                #2;
                clk_en = 1'b1;
            end
        join_none
        run("Q\n", 1'b0, "Q$", "freeze");
        $display("test data done");
    endtask
    task automatic t_err();
        ecnt = 0;
        run("ABCDEFGHIJKL\n", 1'b0, "ABCDEFGHIJKL$", "twelve");
        run("ABCDEFGHIJKLM 1\n", 1'b0, "ABCDEFGHIJKL!", "thirteen");
        run("1A;B\n", 1'b0, "!", "digit start");
        run("SRC 1,\n", 1'b0, "SRC=1,!", "dangling");
        check("errors", $sformatf("%0d", ecnt), "3");
        run("A\n", 1'b0, "A$", "recover");
        $display("test errors done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        hold = 1'b0;
        cyc = 2'h0;
        repeat (12) @(posedge clk_sys);
        #2;
        reset_n = 1'b1;
        @(posedge clk_sys);
        #2;
        t_term();
        t_units();
        t_data();
        t_err();
        final_report();
    end
    // the tests need some 300 cycles; this cuts a hang at 20000
    initial begin
        #400000;
        fail_count++;
        final_report();
    end
endmodule // test_spp_parser
